// ==== lwm_ctrl.sv ====
// Command decoder for program window, nonvolatile control and display power
// Function
// [RQ1] Two-byte command loads 8-bit window start column from second byte.
// [RQ2] Two-byte command loads 7-bit window start page; top parameter bit ignored.
// [RQ3] Two-byte command loads 8-bit window end column from second byte.
// [RQ4] Two-byte command loads 7-bit window end page from second byte.
// [RQ5] Single-byte command bit 0 selects inside (0) or outside (1) mode.
// [RQ6] Mode change leaves pointers untouched; host repositions them afterwards.
// [RQ7] Outside mode drops data bytes landing inside the window.
// [RQ8] Nonvolatile command code: idle, read, erase, program; top bit reserved.
// [RQ9] Nonvolatile enable bit clears itself when the operation completes.
// [RQ10] Valid bit low ignores stored nonvolatile value; high uses it.
// [RQ11] Host keeps the nonvolatile test bit at zero in normal use.
// [RQ12] Bias codes 0..3 select ratios 5, 10, 11, 12.
// [RQ13] Thermal slope codes 0..3 select -0.05, -0.10, -0.15, 0.00 %/C.
// [RQ14] Two-bit field selects charge pump or external high drive voltage.
// [RQ15] Line rate field picks base rate; frame rate is line/mux above 108.
// [RQ16] Mux below 107, 80, 53, 40 divides line rate 1.5, 2, 3, 4.
// [RQ17] Mux rate comes only from the last-row index register.
// [RQ18] Driver enable idles drivers; idle column drivers are shorted.
// [RQ19] Row driver to pixel row mapping never changes.
// [RQ20] Driver enable overrides all-on and invert flags.
// [RQ21] Driver enable 0 idles drivers and enters sleep.
// [RQ22] Driver enable 1 leaves sleep, restores supplies, then starts drivers.
// [RQ23] Host should pick bias ratio 5 when mux is below 40.
// [RQ24] Wrap-around restarts pointer and steps the other; else pointer stops.
// [RQ25] Inside mode confines writes to the window, wrapping at its edges; code wraps there only with wrap-around set, else stops.
`include "lwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lwm_ctrl import lwm_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HOST_VALID,
	input wire logic HOST_CD,
	input wire logic [7:0] HOST_BYTE,
	input wire logic NV_DONE,
	output var lwm_win_s WIN_REGS,
	output var lwm_nv_s NV_CTRL,
	output var lwm_ram_s RAM_WR,
	output logic [7:0] COLUMN_POINTER,
	output logic [6:0] ROW_BLOCK_POINTER,
	output logic [3:0] BIAS_RATIO,
	output logic [7:0] THERMAL_COEF,
	output logic [1:0] BOOST_SOURCE_SELECT,
	output logic [1:0] LINE_RATE_SELECT,
	output logic [2:0] LINE_DIV,
	output logic [7:0] LAST_ROW_INDEX,
	output logic [1:0] SHADE_MODE,
	output logic SLEEP,
	output logic SUPPLY_ON,
	output logic ROW_DRIVER_ON,
	output logic COLUMN_DRIVER_ON,
	output logic COLUMN_SHORT,
	output logic ALL_ON_EFF,
	output logic INVERT_EFF
);
	lwm_pend_e pend_ff, nxt_pend;
	lwm_win_s win_ff, nxt_win;
	lwm_nv_s nv_ff, nxt_nv;
	lwm_ram_s ram_ff, nxt_ram;
	lwm_walk_s walk_cfg;
	logic [1:0] bias_ff, nxt_bias, slope_ff, nxt_slope, boost_ff, nxt_boost;
	logic [1:0] lrate_ff, nxt_lrate, shade_ff, nxt_shade;
	logic [7:0] last_row_ff, nxt_last_row;
	logic wa_ff, nxt_wa, order_ff, nxt_order, pdir_ff, nxt_pdir;
	logic drv_en_ff, nxt_drv_en, all_on_ff, nxt_all_on, inv_ff, nxt_inv;
	logic [3:0] br_ff, nxt_br;
	logic [7:0] tc_ff, nxt_tc;
	logic [2:0] div_ff, nxt_div;
	logic done_s1_ff, done_s2_ff, done_s3_ff;
	logic cmd_wr, data_wr, in_win, discard, load_col, load_page, done_evt;
	logic [8:0] mux_rate;
	logic [7:0] col_ptr;
	logic [6:0] page_ptr;
	logic pwr_sleep, pwr_supply, pwr_drv;

	assign cmd_wr = HOST_VALID && !HOST_CD;
	assign data_wr = HOST_VALID && HOST_CD;
	assign done_evt = done_s2_ff && !done_s3_ff;

	// [RQ7] Window hit test
	always_comb begin
		in_win = (col_ptr >= win_ff.sc) && (col_ptr <= win_ff.ec)
			&& (page_ptr >= win_ff.sp) && (page_ptr <= win_ff.ep);
		discard = win_ff.window_outside_select && in_win;
	end

	// [RQ25] Inside mode bounds
	always_comb begin
		walk_cfg.wrap_around = wa_ff;
		walk_cfg.page_first = order_ff;
		walk_cfg.page_down = pdir_ff;
		if (win_ff.window_outside_select) begin
			walk_cfg.col_lo = 8'h00;
			walk_cfg.col_hi = `LWM_COL_MAX;
			walk_cfg.page_lo = 7'h00;
			walk_cfg.page_hi = `LWM_PAGE_MAX;
		end else begin
			walk_cfg.col_lo = win_ff.sc;
			walk_cfg.col_hi = win_ff.ec;
			walk_cfg.page_lo = win_ff.sp;
			walk_cfg.page_hi = win_ff.ep;
		end
	end

	assign load_col = cmd_wr && (pend_ff == PEND_COLP);
	assign load_page = cmd_wr && (pend_ff == PEND_PAGEP);

	// [RQ24] Pointer walk
	lwm_ptr_walk u_walk (
		.clk(CLK),
		.rst(RST),
		.cfg(walk_cfg),
		.load_col(load_col),
		.load_page(load_page),
		.load_val(HOST_BYTE),
		.step(data_wr),
		.column_pointer(col_ptr),
		.row_block_pointer(page_ptr)
	);

	// [RQ22] Wake sequence
	lwm_pwr_seq u_pwr (
		.clk(CLK),
		.rst(RST),
		.driver_enable_bit(drv_en_ff),
		.sleep(pwr_sleep),
		.supply_on(pwr_supply),
		.drivers_on(pwr_drv)
	);

	always_comb begin
		nxt_pend = pend_ff;
		nxt_win = win_ff;
		nxt_nv = nv_ff;
		nxt_bias = bias_ff;
		nxt_slope = slope_ff;
		nxt_boost = boost_ff;
		nxt_lrate = lrate_ff;
		nxt_shade = shade_ff;
		nxt_last_row = last_row_ff;
		nxt_wa = wa_ff;
		nxt_order = order_ff;
		nxt_pdir = pdir_ff;
		nxt_drv_en = drv_en_ff;
		nxt_all_on = all_on_ff;
		nxt_inv = inv_ff;
		nxt_ram = '0;
		// [RQ9] Enable clears on completion or reserved code
		if (nv_ff.enable && (done_evt || nv_ff.op[2])) begin
			nxt_nv.enable = 1'b0;
		end
		if (data_wr) begin
			// [RQ7] Drop hits in outside mode
			nxt_ram.we = !discard;
			nxt_ram.col = col_ptr;
			nxt_ram.page = page_ptr;
			nxt_ram.data = HOST_BYTE;
		end else if (cmd_wr && pend_ff != PEND_NONE) begin
			nxt_pend = PEND_NONE;
			unique case (pend_ff)
				// [RQ1] Start column
				PEND_SC: nxt_win.sc = HOST_BYTE;
				// [RQ2] Start page
				PEND_SP: nxt_win.sp = HOST_BYTE[6:0];
				// [RQ3] End column
				PEND_EC: nxt_win.ec = HOST_BYTE;
				// [RQ4] End page
				PEND_EP: nxt_win.ep = HOST_BYTE[6:0];
				PEND_NV: begin
					// [RQ8] Operation code and flags
					nxt_nv.op = HOST_BYTE[2:0];
					nxt_nv.enable = HOST_BYTE[3];
					// [RQ10] Stored value valid
					nxt_nv.valid = HOST_BYTE[4];
					nxt_nv.test = HOST_BYTE[5];
				end
				// [RQ17] Mux rate source
				PEND_LAST: nxt_last_row = HOST_BYTE;
				PEND_COLP: nxt_pend = PEND_NONE;
				PEND_PAGEP: nxt_pend = PEND_NONE;
				default: nxt_pend = PEND_NONE;
			endcase
		end else if (cmd_wr) begin
			if (HOST_BYTE == `LWM_CMD_WIN_SC) begin
				nxt_pend = PEND_SC;
			end else if (HOST_BYTE == `LWM_CMD_WIN_SP) begin
				nxt_pend = PEND_SP;
			end else if (HOST_BYTE == `LWM_CMD_WIN_EC) begin
				nxt_pend = PEND_EC;
			end else if (HOST_BYTE == `LWM_CMD_WIN_EP) begin
				nxt_pend = PEND_EP;
			end else if (HOST_BYTE == `LWM_CMD_NV_CTRL) begin
				nxt_pend = PEND_NV;
			end else if (HOST_BYTE == `LWM_CMD_LAST_ROW) begin
				nxt_pend = PEND_LAST;
			end else if (HOST_BYTE == `LWM_CMD_COL_PTR) begin
				nxt_pend = PEND_COLP;
			end else if (HOST_BYTE == `LWM_CMD_PAGE_PTR) begin
				nxt_pend = PEND_PAGEP;
			end else if ((HOST_BYTE & `LWM_MSK_1BIT) == `LWM_CMD_WIN_MODE) begin
				// [RQ5] Mode bit only
				// [RQ6] Pointers untouched
				nxt_win.window_outside_select = HOST_BYTE[0];
			end else if ((HOST_BYTE & `LWM_MSK_2BIT) == `LWM_CMD_BIAS) begin
				nxt_bias = HOST_BYTE[1:0];
			end else if ((HOST_BYTE & `LWM_MSK_2BIT) == `LWM_CMD_SLOPE) begin
				nxt_slope = HOST_BYTE[1:0];
			end else if ((HOST_BYTE & `LWM_MSK_2BIT) == `LWM_CMD_BOOST) begin
				// [RQ14] Drive voltage source
				nxt_boost = HOST_BYTE[1:0];
			end else if ((HOST_BYTE & `LWM_MSK_2BIT) == `LWM_CMD_LINE_RATE) begin
				// [RQ15] Base line rate
				nxt_lrate = HOST_BYTE[1:0];
			end else if ((HOST_BYTE & `LWM_MSK_1BIT) == `LWM_CMD_ALL_ON) begin
				nxt_all_on = HOST_BYTE[0];
			end else if ((HOST_BYTE & `LWM_MSK_1BIT) == `LWM_CMD_INVERT) begin
				nxt_inv = HOST_BYTE[0];
			end else if ((HOST_BYTE & `LWM_MSK_3BIT) == `LWM_CMD_DISP_EN) begin
				// [RQ21] Enable bit drives sleep
				nxt_drv_en = HOST_BYTE[0];
				nxt_shade = HOST_BYTE[2:1];
			end else if ((HOST_BYTE & `LWM_MSK_3BIT) == `LWM_CMD_ADDR_CTRL) begin
				nxt_wa = HOST_BYTE[0];
				nxt_order = HOST_BYTE[1];
				nxt_pdir = HOST_BYTE[2];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_ff <= PEND_NONE;
			win_ff <= '{sc: 8'h00, sp: 7'h00, ec: `LWM_RST_WIN_EC, ep: `LWM_RST_WIN_EP,
				window_outside_select: 1'b0};
			nv_ff <= '0;
			ram_ff <= '0;
			bias_ff <= `LWM_RST_BIAS;
			slope_ff <= 2'h0;
			boost_ff <= 2'h0;
			lrate_ff <= 2'h0;
			shade_ff <= 2'(`LWM_RST_DISP >> 1);
			last_row_ff <= `LWM_RST_LAST_ROW;
			wa_ff <= 1'b0;
			order_ff <= 1'b0;
			pdir_ff <= 1'b0;
			drv_en_ff <= 1'b0;
			all_on_ff <= 1'b0;
			inv_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			win_ff <= nxt_win;
			nv_ff <= nxt_nv;
			ram_ff <= nxt_ram;
			bias_ff <= nxt_bias;
			slope_ff <= nxt_slope;
			boost_ff <= nxt_boost;
			lrate_ff <= nxt_lrate;
			shade_ff <= nxt_shade;
			last_row_ff <= nxt_last_row;
			wa_ff <= nxt_wa;
			order_ff <= nxt_order;
			pdir_ff <= nxt_pdir;
			drv_en_ff <= nxt_drv_en;
			all_on_ff <= nxt_all_on;
			inv_ff <= nxt_inv;
		end
	end

	// Completion pin synchroniser
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			done_s1_ff <= 1'b0;
			done_s2_ff <= 1'b0;
			done_s3_ff <= 1'b0;
		end else begin
			done_s1_ff <= NV_DONE;
			done_s2_ff <= done_s1_ff;
			done_s3_ff <= done_s2_ff;
		end
	end

	assign mux_rate = {1'b0, last_row_ff} + 9'h001;

	always_comb begin
		// [RQ12] Bias ratio map
		unique case (bias_ff)
			2'h0: nxt_br = `LWM_BR_0;
			2'h1: nxt_br = `LWM_BR_1;
			2'h2: nxt_br = `LWM_BR_2;
			2'h3: nxt_br = `LWM_BR_3;
		endcase
		// [RQ13] Thermal slope map
		unique case (slope_ff)
			2'h0: nxt_tc = `LWM_TC_0;
			2'h1: nxt_tc = `LWM_TC_1;
			2'h2: nxt_tc = `LWM_TC_2;
			2'h3: nxt_tc = `LWM_TC_3;
		endcase
		// [RQ16] Line rate scaling
		if (mux_rate < `LWM_MUX_DIV4) begin
			nxt_div = DIV_4;
		end else if (mux_rate < `LWM_MUX_DIV3) begin
			nxt_div = DIV_3;
		end else if (mux_rate < `LWM_MUX_DIV2) begin
			nxt_div = DIV_2;
		end else if (mux_rate < `LWM_MUX_DIV15) begin
			nxt_div = DIV_1P5;
		end else begin
			nxt_div = DIV_1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			br_ff <= `LWM_BR_3;
			tc_ff <= `LWM_TC_0;
			div_ff <= DIV_1;
		end else begin
			br_ff <= nxt_br;
			tc_ff <= nxt_tc;
			div_ff <= nxt_div;
		end
	end

	assign WIN_REGS = win_ff;
	assign NV_CTRL = nv_ff;
	assign RAM_WR = ram_ff;
	assign COLUMN_POINTER = col_ptr;
	assign ROW_BLOCK_POINTER = page_ptr;
	assign BIAS_RATIO = br_ff;
	assign THERMAL_COEF = tc_ff;
	assign BOOST_SOURCE_SELECT = boost_ff;
	assign LINE_RATE_SELECT = lrate_ff;
	assign LINE_DIV = div_ff;
	assign LAST_ROW_INDEX = last_row_ff;
	assign SHADE_MODE = shade_ff;
	assign SLEEP = pwr_sleep;
	assign SUPPLY_ON = pwr_supply;
	// [RQ19] One enable for all rows, no remap
	assign ROW_DRIVER_ON = pwr_drv;
	// [RQ18] Idle columns shorted
	assign COLUMN_DRIVER_ON = pwr_drv;
	assign COLUMN_SHORT = !pwr_drv;
	// [RQ20] Driver enable overrides
	assign ALL_ON_EFF = pwr_drv && all_on_ff;
	assign INVERT_EFF = pwr_drv && inv_ff;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence s_param_byte(lwm_pend_e p);
		cmd_wr && pend_ff == p;
	endsequence

	property p_win_sc;
		s_param_byte(PEND_SC) |=> WIN_REGS.sc == $past(HOST_BYTE);
	endproperty
	a_win_sc: assert property (p_win_sc) else $error("start column not loaded"); // [RQ1]

	property p_win_sp;
		s_param_byte(PEND_SP) |=> WIN_REGS.sp == $past(HOST_BYTE[6:0]);
	endproperty
	a_win_sp: assert property (p_win_sp) else $error("start page not loaded"); // [RQ2]

	property p_mode_keeps_ptr;
		pend_ff == PEND_NONE && cmd_wr && (HOST_BYTE & `LWM_MSK_1BIT) == `LWM_CMD_WIN_MODE
			|=> $stable(COLUMN_POINTER) && $stable(ROW_BLOCK_POINTER)
			&& WIN_REGS.window_outside_select == $past(HOST_BYTE[0]);
	endproperty
	a_mode_keeps_ptr: assert property (p_mode_keeps_ptr) else $error("mode change moved ptr"); // [RQ6]

	property p_outside_drop;
		data_wr && win_ff.window_outside_select && in_win |=> !RAM_WR.we;
	endproperty
	a_outside_drop: assert property (p_outside_drop) else $error("window hit was written"); // [RQ7]

	property p_nv_clear;
		nv_ff.enable && done_evt && !(cmd_wr && pend_ff == PEND_NV) |=> !NV_CTRL.enable;
	endproperty
	a_nv_clear: assert property (p_nv_clear) else $error("enable not cleared"); // [RQ9]

	property p_bias_five;
		bias_ff == 2'h0 |=> BIAS_RATIO == 4'h5;
	endproperty
	a_bias_five: assert property (p_bias_five) else $error("bias code 0 not ratio 5"); // [RQ12]

	property p_div_four;
		last_row_ff < 8'h27 |=> LINE_DIV == DIV_4;
	endproperty
	a_div_four: assert property (p_div_four) else $error("low mux not divided by 4"); // [RQ16]

	property p_override;
		!ROW_DRIVER_ON |-> !ALL_ON_EFF && !INVERT_EFF && COLUMN_SHORT;
	endproperty
	a_override: assert property (p_override) else $error("flags active while idle"); // [RQ20]

	property p_sleep_entry;
		!drv_en_ff |=> SLEEP && !ROW_DRIVER_ON && !SUPPLY_ON;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep on disable"); // [RQ21]

	sequence s_wake;
		SLEEP ##1 !SLEEP && !SUPPLY_ON ##1 SUPPLY_ON && !ROW_DRIVER_ON;
	endsequence

	property p_wake_order;
		$rose(ROW_DRIVER_ON) |-> $past(SUPPLY_ON) && !SLEEP;
	endproperty
	a_wake_order: assert property (p_wake_order) else $error("drivers before supplies"); // [RQ22]

	property p_wake_steps;
		drv_en_ff [*3] and s_wake |=> !ROW_DRIVER_ON;
	endproperty
	a_wake_steps: assert property (p_wake_steps) else $error("supply restore skipped"); // [RQ22]
endmodule
`default_nettype wire

// ==== lwm_host_model.sv ====
// Host side model that issues command and data bytes
`timescale 1ns/1ps
`default_nettype none
module lwm_host_model (
	input wire logic clk,
	output logic host_valid,
	output logic host_cd,
	output logic [7:0] host_byte,
	output logic nv_done
);
	initial begin
		host_valid = 1'b0;
		host_cd = 1'b0;
		host_byte = 8'h00;
		nv_done = 1'b0;
	end
	// One byte, held through the taking edge
	task automatic send(input logic cd, input logic [7:0] b);
		@(negedge clk);
		host_valid = 1'b1;
		host_cd = cd;
		host_byte = b;
		@(posedge clk);
		@(negedge clk);
		host_valid = 1'b0;
		host_byte = ~b;
	endtask
	task automatic cmd2(input logic [7:0] op, input logic [7:0] prm);
		send(1'b0, op);
		send(1'b0, prm);
	endtask
	task automatic nv_ctrl(input logic [7:0] prm);
		cmd2(8'hb8, prm & 8'hdf);
	endtask
	task automatic done_pulse();
		@(negedge clk);
		nv_done = 1'b1;
		repeat (2) @(negedge clk);
		nv_done = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== lwm_params.svh ====
// Command codes, reset values and timing counts of the window and display control block
`ifndef LWM_PARAMS_SVH
`define LWM_PARAMS_SVH
`define LWM_CMD_WIN_SC 8'hf4
`define LWM_CMD_WIN_SP 8'hf5
`define LWM_CMD_WIN_EC 8'hf6
`define LWM_CMD_WIN_EP 8'hf7
`define LWM_CMD_WIN_MODE 8'hf8
`define LWM_CMD_NV_CTRL 8'hb8
`define LWM_CMD_LAST_ROW 8'hf1
`define LWM_CMD_COL_PTR 8'h10
`define LWM_CMD_PAGE_PTR 8'h11
`define LWM_CMD_BIAS 8'he8
`define LWM_CMD_LINE_RATE 8'ha0
`define LWM_CMD_ALL_ON 8'ha4
`define LWM_CMD_INVERT 8'ha6
`define LWM_CMD_DISP_EN 8'ha8
`define LWM_CMD_ADDR_CTRL 8'h88
`define LWM_CMD_SLOPE 8'h24
`define LWM_CMD_BOOST 8'h2c
`define LWM_MSK_1BIT 8'hfe
`define LWM_MSK_2BIT 8'hfc
`define LWM_MSK_3BIT 8'hf8
`define LWM_COL_MAX 8'hff
`define LWM_PAGE_MAX 7'h7f
`define LWM_RST_WIN_EC 8'hff
`define LWM_RST_WIN_EP 7'h7f
`define LWM_RST_LAST_ROW 8'h9f
`define LWM_RST_BIAS 2'h3
`define LWM_RST_DISP 3'h6
`define LWM_MUX_FULL 9'h06c
`define LWM_MUX_DIV15 9'h06b
`define LWM_MUX_DIV2 9'h050
`define LWM_MUX_DIV3 9'h035
`define LWM_MUX_DIV4 9'h028
`define LWM_BR_0 4'h5
`define LWM_BR_1 4'ha
`define LWM_BR_2 4'hb
`define LWM_BR_3 4'hc
`define LWM_TC_0 8'hfb
`define LWM_TC_1 8'hf6
`define LWM_TC_2 8'hf1
`define LWM_TC_3 8'h00
`define LWM_PWR_UP_NS 10000
`define LWM_CLK_MHZ 125
`endif

// ==== lwm_pkg.sv ====
// Types shared by the window and display control block
package lwm_pkg;
	typedef enum logic [8:0] {
		PEND_NONE = 9'h001, PEND_SC = 9'h002, PEND_SP = 9'h004, PEND_EC = 9'h008,
		PEND_EP = 9'h010, PEND_NV = 9'h020, PEND_LAST = 9'h040, PEND_COLP = 9'h080,
		PEND_PAGEP = 9'h100
	} lwm_pend_e;
	typedef enum logic [3:0] {
		PS_SLEEP = 4'h1, PS_WAKE = 4'h2, PS_POWER = 4'h4, PS_ACTIVE = 4'h8
	} lwm_pwr_e;
	typedef enum logic [2:0] {
		DIV_1 = 3'h0, DIV_1P5 = 3'h1, DIV_2 = 3'h2, DIV_3 = 3'h3, DIV_4 = 3'h4
	} lwm_div_e;
	typedef struct packed {
		logic [7:0] col_lo;
		logic [7:0] col_hi;
		logic [6:0] page_lo;
		logic [6:0] page_hi;
		logic wrap_around;
		logic page_first;
		logic page_down;
	} lwm_walk_s;
	typedef struct packed {
		logic [7:0] sc;
		logic [6:0] sp;
		logic [7:0] ec;
		logic [6:0] ep;
		logic window_outside_select;
	} lwm_win_s;
	typedef struct packed {
		logic test;
		logic valid;
		logic enable;
		logic [2:0] op;
	} lwm_nv_s;
	typedef struct packed {
		logic we;
		logic [7:0] col;
		logic [6:0] page;
		logic [7:0] data;
	} lwm_ram_s;
endpackage

// ==== lwm_ptr_walk.sv ====
// Column and row block pointer advance within a bounded rectangle
`timescale 1ns/1ps
`default_nettype none
module lwm_ptr_walk import lwm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input var lwm_walk_s cfg,
	input wire logic load_col,
	input wire logic load_page,
	input wire logic [7:0] load_val,
	input wire logic step,
	output logic [7:0] column_pointer,
	output logic [6:0] row_block_pointer
);
	logic [7:0] col_ff, nxt_col;
	logic [6:0] page_ff, nxt_page;
	logic col_edge, page_edge;
	logic [6:0] page_stepped;
	logic [7:0] col_stepped;

	always_comb begin
		col_edge = (col_ff == cfg.col_hi);
		page_edge = cfg.page_down ? (page_ff == cfg.page_lo) : (page_ff == cfg.page_hi);
		page_stepped = cfg.page_down ? (page_edge ? cfg.page_hi : page_ff - 7'h01)
			: (page_edge ? cfg.page_lo : page_ff + 7'h01);
		col_stepped = col_edge ? cfg.col_lo : col_ff + 8'h01;
		nxt_col = col_ff;
		nxt_page = page_ff;
		if (load_col) begin
			nxt_col = load_val;
		end else if (load_page) begin
			nxt_page = load_val[6:0];
		end else if (step) begin
			// Wrap restarts, else stop
			if (!cfg.page_first) begin
				if (!col_edge) begin
					nxt_col = col_stepped;
				end else if (cfg.wrap_around) begin
					nxt_col = col_stepped;
					nxt_page = page_stepped;
				end
			end else begin
				if (!page_edge) begin
					nxt_page = page_stepped;
				end else if (cfg.wrap_around) begin
					nxt_page = page_stepped;
					nxt_col = col_stepped;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			col_ff <= 8'h00;
			page_ff <= 7'h00;
		end else begin
			col_ff <= nxt_col;
			page_ff <= nxt_page;
		end
	end

	assign column_pointer = col_ff;
	assign row_block_pointer = page_ff;
endmodule
`default_nettype wire

// ==== lwm_pwr_seq.sv ====
// Sleep exit, supply restore and driver turn-on sequencing
`include "lwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lwm_pwr_seq import lwm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic driver_enable_bit,
	output logic sleep,
	output logic supply_on,
	output logic drivers_on
);
	localparam int PWR_CYC = (`LWM_PWR_UP_NS * `LWM_CLK_MHZ + 999) / 1000;
	lwm_pwr_e st_ff, nxt_st;
	logic [10:0] cnt_ff, nxt_cnt;

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = 11'h000;
		if (!driver_enable_bit) begin
			nxt_st = PS_SLEEP;
		end else begin
			unique case (st_ff)
				PS_SLEEP: nxt_st = PS_WAKE;
				PS_WAKE: nxt_st = PS_POWER;
				PS_POWER: begin
					nxt_cnt = cnt_ff + 11'h001;
					if (cnt_ff == 11'(PWR_CYC - 1)) begin
						nxt_st = PS_ACTIVE;
					end
				end
				PS_ACTIVE: nxt_st = PS_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= PS_SLEEP;
			cnt_ff <= 11'h000;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end

	assign sleep = (st_ff == PS_SLEEP);
	assign supply_on = (st_ff == PS_POWER) || (st_ff == PS_ACTIVE);
	assign drivers_on = (st_ff == PS_ACTIVE);
endmodule
`default_nettype wire

// ==== lwm_tb.sv ====
// Testbench of the window and display control block
`include "lwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb import lwm_pkg::*; ;
	logic clk, rst, hv, hcd, nvd, sleep, sup, row_on, col_on, col_sh, all_on, inv;
	logic [7:0] hb, cptr, tcoef, last_row;
	logic [6:0] pptr;
	logic [3:0] bias;
	logic [1:0] boost, lrate, shade;
	logic [2:0] ldiv;
	lwm_win_s win;
	lwm_nv_s nv;
	lwm_ram_s ram;
	int num_errors = 0;
	int cmp_count = 0;
	localparam logic [3:0] BRT [4] = '{`LWM_BR_0, `LWM_BR_1, `LWM_BR_2, `LWM_BR_3};
	localparam logic [7:0] TCT [4] = '{`LWM_TC_0, `LWM_TC_1, `LWM_TC_2, `LWM_TC_3};
	localparam int MUXV [9] = '{108, 107, 106, 80, 79, 53, 52, 40, 39};
	localparam logic [2:0] DIVV [9] = '{DIV_1, DIV_1, DIV_1P5, DIV_1P5, DIV_2, DIV_2, DIV_3, DIV_3,
		DIV_4};
	lwm_host_model h (.clk(clk), .host_valid(hv), .host_cd(hcd), .host_byte(hb), .nv_done(nvd));
	lwm_ctrl dut (.CLK(clk), .RST(rst), .HOST_VALID(hv), .HOST_CD(hcd), .HOST_BYTE(hb),
		.NV_DONE(nvd), .WIN_REGS(win), .NV_CTRL(nv), .RAM_WR(ram), .COLUMN_POINTER(cptr),
		.ROW_BLOCK_POINTER(pptr), .BIAS_RATIO(bias), .THERMAL_COEF(tcoef),
		.BOOST_SOURCE_SELECT(boost), .LINE_RATE_SELECT(lrate), .LINE_DIV(ldiv),
		.LAST_ROW_INDEX(last_row), .SHADE_MODE(shade), .SLEEP(sleep), .SUPPLY_ON(sup),
		.ROW_DRIVER_ON(row_on), .COLUMN_DRIVER_ON(col_on), .COLUMN_SHORT(col_sh),
		.ALL_ON_EFF(all_on), .INVERT_EFF(inv));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		chk(win, {8'h00, 7'h00, `LWM_RST_WIN_EC, `LWM_RST_WIN_EP, 1'b0});
		chk({sleep, sup, row_on, col_on, col_sh}, 5'b10001);
		chk(bias, `LWM_BR_3);
	endtask
	task automatic t_win();
		h.cmd2(`LWM_CMD_WIN_SC, 8'h81);
		chk(win.sc, 8'h81);
		h.cmd2(`LWM_CMD_WIN_SP, 8'hc5);
		chk(win.sp, 7'h45);
		h.cmd2(`LWM_CMD_WIN_EC, 8'hfe);
		chk(win.ec, 8'hfe);
		h.cmd2(`LWM_CMD_WIN_EP, 8'h93);
		chk(win.ep, 7'h13);
	endtask
	task automatic t_codes();
		for (int i = 0; i < 4; i++) begin
			h.send(1'b0, `LWM_CMD_BIAS | 8'(i));
			h.send(1'b0, `LWM_CMD_SLOPE | 8'(i));
			chk(bias, BRT[i]);
			h.send(1'b0, `LWM_CMD_BOOST | 8'(i));
			chk(tcoef, TCT[i]);
			chk(boost, i);
			h.send(1'b0, `LWM_CMD_LINE_RATE | 8'(i));
			chk(lrate, i);
		end
	endtask
	task automatic t_div();
		for (int i = 0; i < 9; i++) begin
			h.cmd2(`LWM_CMD_LAST_ROW, 8'(MUXV[i] - 1));
			@(negedge clk);
			chk(last_row, MUXV[i] - 1);
			chk(ldiv, DIVV[i]);
		end
		h.send(1'b0, `LWM_CMD_BIAS);
		h.cmd2(`LWM_CMD_LAST_ROW, `LWM_RST_LAST_ROW);
	endtask
	task automatic t_nv();
		for (int i = 0; i < 4; i++) begin
			h.nv_ctrl(8'h10 | 8'(i));
			chk(nv, 6'h10 | 6'(i));
		end
		h.nv_ctrl(8'h1b);
		chk(nv, 6'h1b);
		h.done_pulse();
		repeat (4) @(negedge clk);
		chk(nv, 6'h13);
		h.nv_ctrl(8'h0c);
		@(negedge clk);
		chk(nv, 6'h04);
	endtask
	task automatic t_ram();
		h.cmd2(`LWM_CMD_WIN_SC, 8'h02);
		h.cmd2(`LWM_CMD_WIN_SP, 8'h00);
		h.cmd2(`LWM_CMD_WIN_EC, 8'h03);
		h.cmd2(`LWM_CMD_WIN_EP, 8'h01);
		h.send(1'b0, `LWM_CMD_WIN_MODE | 8'h01);
		chk(win.window_outside_select, 1'b1);
		h.cmd2(`LWM_CMD_COL_PTR, 8'h00);
		h.cmd2(`LWM_CMD_PAGE_PTR, 8'h00);
		h.send(1'b0, `LWM_CMD_ADDR_CTRL);
		for (int i = 0; i < 5; i++) begin
			h.send(1'b1, 8'ha0 + 8'(i));
			chk(ram.we, i < 2 || i == 4);
		end
		h.send(1'b0, `LWM_CMD_WIN_MODE);
		chk({win.window_outside_select, cptr, pptr}, {1'b0, 8'h05, 7'h00});
		h.send(1'b0, `LWM_CMD_ADDR_CTRL | 8'h01);
		h.cmd2(`LWM_CMD_COL_PTR, 8'h02);
		h.cmd2(`LWM_CMD_PAGE_PTR, 8'h00);
		for (int i = 0; i < 3; i++) begin
			h.send(1'b1, 8'(i));
			chk(ram, {1'b1, 8'(i == 2 ? 2 : 2 + i), 7'(i == 2), 8'(i)});
		end
		// Page first, page down, no wrap: stops at the lowest page
		h.send(1'b0, `LWM_CMD_ADDR_CTRL | 8'h06);
		for (int i = 0; i < 3; i++) begin
			h.send(1'b1, 8'h10 + 8'(i));
			chk(ram, {1'b1, 8'h03, 7'(i == 0), 8'h10 + 8'(i)});
		end
		h.send(1'b0, `LWM_CMD_ADDR_CTRL | 8'h07);
		h.send(1'b1, 8'h20);
		chk(ram, {1'b1, 8'h03, 7'h00, 8'h20});
		chk({cptr, pptr}, {8'h02, 7'h01});
	endtask
	task automatic t_power();
		int n;
		n = 0;
		h.send(1'b0, `LWM_CMD_DISP_EN | 8'h07);
		repeat (3) @(negedge clk);
		chk({sleep, sup, row_on}, 3'b010);
		while (row_on !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(n, (`LWM_PWR_UP_NS * `LWM_CLK_MHZ) / 1000 - 1);
		chk({col_on, col_sh, shade}, 4'b1011);
		h.send(1'b0, `LWM_CMD_ALL_ON | 8'h01);
		h.send(1'b0, `LWM_CMD_INVERT | 8'h01);
		chk({all_on, inv}, 2'b11);
		h.send(1'b0, `LWM_CMD_DISP_EN | 8'h06);
		repeat (2) @(negedge clk);
		chk({sleep, sup, row_on, col_on, col_sh, all_on, inv}, 7'b1000100);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#40000;
		num_errors++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_win();
		t_codes();
		t_div();
		t_nv();
		t_ram();
		t_power();
		print_verdict();
	end
endmodule
`default_nettype wire
